// *** logic/ccou_channel.v ***
// one capture/compare channel: capture path, compare match, output unit
// assumes count and arrive come from the timer core in the same clock
`default_nettype none
`include "ccou_defines.vh"
module ccou_channel (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // timer core
  input wire tick,
  input wire arrive,
  input wire tclr,
  input wire [15:0] count,
  input wire peq,
  // capture sources
  input wire in_a,
  input wire in_b,
  // register access
  input wire ctl_we,
  input wire ccr_we,
  input wire ccr_rd,
  input wire flag_clr,
  input wire [15:0] wdata,
  output wire [15:0] ctl_rv,
  output wire [15:0] ccr_v,
  output wire req,
  output wire eq,
  output reg out_q
);
  reg [15:0] ccr_q;
  reg [1:0] em_q;
  reg [1:0] is_q;
  reg [2:0] om_q;
  reg scs_q, synced_input_bit_q, cap_q, ie_q, obit_q, cov_q, flg_q;
  reg lvl_q, unread_q, pend_q;
  wire lvl, rise, fall, edge_hit, cap_now;

  // selected input; upper select bit picks ground or supply by lower bit
  assign lvl = is_q[1] ? is_q[0] : (is_q[0] ? in_b : in_a); // see RULE6
  assign rise = lvl & ~lvl_q;
  assign fall = ~lvl & lvl_q;
  assign edge_hit = (em_q[0] & rise) | (em_q[1] & fall); // see RULE6
  // synced capture waits for the next timer tick, avoiding input races
  assign cap_now = cap_q & (scs_q ? (pend_q | edge_hit) & tick
                                  : edge_hit); // see RULE8
  // match only by counting: arrive is never raised by a count write
  assign eq = arrive & ~cap_q & (count == ccr_q); // see RULE11
  assign req = flg_q & ie_q;
  assign ccr_v = ccr_q;
  assign ctl_rv = {em_q, is_q, scs_q, synced_input_bit_q, 1'b0, cap_q, om_q,
                   ie_q, lvl, obit_q, cov_q, flg_q};

  // control fields and capture bookkeeping
  always @(posedge aclk) begin
    if (!aresetn) begin
      em_q <= 2'h0;
      is_q <= 2'h0;
      om_q <= 3'h0;
      scs_q <= 1'b0;
      cap_q <= 1'b0;
      ie_q <= 1'b0;
      obit_q <= 1'b0;
      lvl_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      lvl_q <= lvl;
      pend_q <= cap_q & scs_q & (pend_q | edge_hit) & ~tick;
      if (ctl_we) begin
        em_q <= wdata[`CCOU_K_EM];
        is_q <= wdata[`CCOU_K_IS];
        om_q <= wdata[`CCOU_K_OM];
        scs_q <= wdata[`CCOU_K_SCS];
        cap_q <= wdata[`CCOU_K_CAP]; // see RULE6
        ie_q <= wdata[`CCOU_K_IE];
        obit_q <= wdata[`CCOU_K_OBIT];
      end
    end
  end

  // value register: no buffering, a write lands at once; capture wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      ccr_q <= 16'h0000;
      unread_q <= 1'b0;
    end else begin
      if (cap_now)
        ccr_q <= count; // see RULE7
      else if (ccr_we)
        ccr_q <= wdata; // see RULE4
      if (cap_now)
        unread_q <= 1'b1;
      else if (ccr_rd)
        unread_q <= 1'b0;
    end
  end

  // flags: hardware set beats software or service clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      flg_q <= 1'b0;
      cov_q <= 1'b0;
      synced_input_bit_q <= 1'b0;
    end else begin
      if (cap_now | eq)
        flg_q <= 1'b1; // see RULE7 RULE11
      else if (flag_clr)
        flg_q <= 1'b0;
      else if (ctl_we)
        flg_q <= wdata[`CCOU_K_FLG]; // see RULE21
      if (cap_now & unread_q)
        cov_q <= 1'b1; // see RULE9
      else if (ctl_we)
        cov_q <= wdata[`CCOU_K_COV];
      if (eq)
        synced_input_bit_q <= lvl; // see RULE11
    end
  end

  // output unit; matches arrive on timer ticks, so changes follow them except mode 0 and the mode 1 tclr clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
    end else begin
      case (om_q) // see RULE12 RULE18
        3'h0: out_q <= obit_q; // see RULE13
        3'h1: begin
          if (tclr)
            out_q <= 1'b0;
          else if (eq)
            out_q <= 1'b1; // see RULE14
        end
        3'h2: begin
          if (peq)
            out_q <= 1'b0;
          else if (eq)
            out_q <= ~out_q; // see RULE15
        end
        3'h3: begin
          if (peq)
            out_q <= 1'b0;
          else if (eq)
            out_q <= 1'b1; // see RULE15
        end
        3'h4: if (eq) out_q <= ~out_q; // see RULE17
        3'h5: if (eq) out_q <= 1'b0; // see RULE14
        3'h6: begin
          if (peq)
            out_q <= 1'b1;
          else if (eq)
            out_q <= ~out_q; // see RULE16
        end
        3'h7: begin
          if (peq)
            out_q <= 1'b1;
          else if (eq)
            out_q <= 1'b0; // see RULE16
        end
        default: out_q <= out_q;
      endcase
    end
  end
endmodule // ccou_channel
`default_nettype wire

// *** logic/ccou_top.v ***
// capture/compare timer: counter core, channels, vectors, register slave
// assumes an AXI4-Lite master on aclk and synchronous capture inputs
//
// Summary of operation
// RULE1 - rewrite while descending: fall to zero, new period after that
// RULE2 - rewrite while rising to at least the count: climb to new period
// RULE3 - rewrite while rising below count: reverse and count down
// RULE4 - channel value writes take effect at once, no dead-time guard
// RULE5 - two or three identical channels, capture or compare each
// RULE6 - capture mode bit, input select, edge select; input level readable
// RULE7 - capture edge copies count into channel register, sets flag
// RULE8 - sync bit delays capture to the next timer tick
// RULE9 - second capture before read sets overflow flag, software clears
// RULE10 - software capture: both edges, upper select set, toggle lower
// RULE11 - compare match sets flag, equal pulse, output, latches input
// RULE12 - eight output modes, changes on timer clock except mode zero; here mode one also clears at once on a count clear (tclr)
// RULE13 - mode zero: output follows software output bit
// RULE14 - mode one sets on match; mode five clears on match
// RULE15 - modes two and three: toggle or set, clear on period
// RULE16 - modes six and seven: toggle or clear, set on period
// RULE17 - mode four toggles on every match
// RULE18 - up/down: matches act in both directions plus period match
// RULE19 - software keeps a mode bit set while changing output mode
// RULE20 - dedicated vector for channel zero, shared vector for rest
// RULE21 - software sets or clears flags; request needs both enables
// RULE22 - channel zero flag highest, auto-cleared when serviced
// RULE23 - only counting triggers matches, count writes do not
// RULE24 - shared vector access clears highest pending flag
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`default_nettype none
`include "ccou_defines.vh"
module ccou_top #(
  parameter NCH = 3,
  parameter TICK_DIV = 1
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address and data
  input wire awvalid,
  output reg awready_q,
  input wire [7:0] awaddr,
  input wire wvalid,
  output reg wready_q,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // write response
  output reg bvalid_q,
  input wire bready,
  output reg [1:0] bresp_q,
  // read address and data
  input wire arvalid,
  output reg arready_q,
  input wire [7:0] araddr,
  output reg rvalid_q,
  input wire rready,
  output reg [31:0] rdata_q,
  output reg [1:0] rresp_q,
  // capture inputs and channel outputs
  input wire [NCH-1:0] cap_in_a,
  input wire [NCH-1:0] cap_in_b,
  output wire [NCH-1:0] chan_out,
  // interrupt requests and service acknowledge
  input wire period_irq_ack,
  output reg irq_period_q,
  output reg irq_shared_q
);
  // ==========
  // decode helpers
  // ==========
  // register exists at this word index
  function valid_idx(input [5:0] idx);
    begin
      valid_idx = (idx < `CCOU_I_VECT + 6'h01) |
        ((idx >= `CCOU_I_CH0) & (idx < `CCOU_I_CH0 + 2 * NCH));
    end
  endfunction

  // shared vector: channel 1, channel 2, then overflow
  function [3:0] vcode(input [2:0] p);
    begin
      if (p[0])
        vcode = `CCOU_V_CH1;
      else if (p[1])
        vcode = `CCOU_V_CH2;
      else if (p[2])
        vcode = `CCOU_V_OVF;
      else
        vcode = `CCOU_V_NONE;
    end
  endfunction

  reg [7:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg aw_full_q, w_full_q;
  reg [1:0] mc_q;
  reg ovie_q, ovf_q, gie_q, tclr_q;
  reg [15:0] cnt_q, shadow_q;
  reg dn_q, arr_q, tick_q;
  reg [7:0] div_q;
  reg [15:0] rd_mux;
  wire wr_go, rd_go, wr_ok, vacc;
  wire [5:0] widx, ridx;
  wire [NCH-1:0] req, ceq, flag_clr, ctl_we, ccr_we, ccr_rd;
  wire [16*NCH-1:0] ctl_rv, ccr_v;
  wire [2:0] vpend;
  wire [3:0] vc;
  wire peq, run;

  // ==========
  // register bus slave
  // ==========
  assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
  assign rd_go = arvalid & arready_q;
  assign widx = awa_q[7:2];
  assign ridx = araddr[7:2];
  // partial writes of the low half-word are dropped on purpose
  assign wr_ok = valid_idx(widx) & (awa_q[1:0] == 2'h0) &
                 (ws_q[1:0] == 2'h3);

  // address and data are held separately, so either may come first
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `CCOU_R_OKAY;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      awready_q <= ~aw_full_q & ~bvalid_q & ~(awvalid & awready_q);
      wready_q <= ~w_full_q & ~bvalid_q & ~(wvalid & wready_q);
      if (awvalid & awready_q) begin
        aw_full_q <= 1'b1;
        awa_q <= awaddr;
      end
      if (wvalid & wready_q) begin
        w_full_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= valid_idx(widx) & (awa_q[1:0] == 2'h0) ?
                   `CCOU_R_OKAY : `CCOU_R_SLVERR;
      end else if (bvalid_q & bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read data mux
  always @* begin
    rd_mux = 16'h0000;
    case (ridx)
      `CCOU_I_CTRL: rd_mux = {10'h000, gie_q, ovf_q, ovie_q, 1'b0, mc_q};
      `CCOU_I_COUNT: rd_mux = cnt_q;
      `CCOU_I_VECT: rd_mux = {12'h000, vc};
      default: begin
        if (valid_idx(ridx) & ridx[0])
          rd_mux = ccr_v[16 * ((ridx - `CCOU_I_CH0) >> 1) +: 16];
        else if (valid_idx(ridx))
          rd_mux = ctl_rv[16 * ((ridx - `CCOU_I_CH0) >> 1) +: 16];
      end
    endcase
  end

  // one read at a time, answered the cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `CCOU_R_OKAY;
    end else begin
      arready_q <= ~rvalid_q & ~rd_go;
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q <= {16'h0000, rd_mux};
        rresp_q <= valid_idx(ridx) & (araddr[1:0] == 2'h0) ?
                   `CCOU_R_OKAY : `CCOU_R_SLVERR;
      end else if (rvalid_q & rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========
  // timer core
  // ==========
  assign run = tick_q & (mc_q != `CCOU_MC_STOP);

  // tick divider; the timer clock is a one-cycle enable
  always @(posedge aclk) begin
    if (!aresetn | tclr_q) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 8'h00);
      div_q <= (div_q >= TICK_DIV[7:0] - 8'h01) ? 8'h00 : div_q + 8'h01;
    end
  end

  // counter; the shadow takes channel 0 at once and steers turn-around
  always @(posedge aclk) begin
    if (!aresetn) begin
      mc_q <= `CCOU_MC_STOP;
      ovie_q <= 1'b0;
      gie_q <= 1'b0;
      ovf_q <= 1'b0;
      tclr_q <= 1'b0;
      cnt_q <= 16'h0000;
      shadow_q <= 16'h0000;
      dn_q <= 1'b0;
      arr_q <= 1'b0;
    end else begin
      shadow_q <= ccr_v[15:0]; // see RULE1
      tclr_q <= wr_go & wr_ok & (widx == `CCOU_I_CTRL) &
                wd_q[`CCOU_C_CLR];
      arr_q <= 1'b0;
      if (wr_go & wr_ok & (widx == `CCOU_I_CTRL)) begin
        mc_q <= wd_q[`CCOU_C_MC];
        ovie_q <= wd_q[`CCOU_C_OVIE];
        gie_q <= wd_q[`CCOU_C_GIE];
      end
      // count writes do not raise arrive, so they match nothing
      if (tclr_q) begin
        cnt_q <= 16'h0000;
        dn_q <= 1'b0;
      end else if (wr_go & wr_ok & (widx == `CCOU_I_COUNT)) begin
        cnt_q <= wd_q[15:0]; // see RULE23
      end else if (run) begin
        case (mc_q)
          `CCOU_MC_UP: begin
            if (shadow_q != 16'h0000) begin
              arr_q <= 1'b1;
              cnt_q <= (cnt_q >= shadow_q) ? 16'h0000 : cnt_q + 16'h0001;
            end
          end
          `CCOU_MC_CONT: begin
            arr_q <= 1'b1;
            cnt_q <= cnt_q + 16'h0001;
          end
          `CCOU_MC_UPDN: begin
            if (shadow_q != 16'h0000) begin
              arr_q <= 1'b1;
              if (dn_q & (cnt_q == 16'h0000)) begin
                dn_q <= 1'b0;
                cnt_q <= 16'h0001;
              end else if (dn_q) begin
                cnt_q <= cnt_q - 16'h0001; // see RULE1
              end else if (cnt_q >= shadow_q) begin
                dn_q <= 1'b1;
                cnt_q <= cnt_q - 16'h0001; // see RULE3
              end else begin
                cnt_q <= cnt_q + 16'h0001; // see RULE2
              end
            end
          end
          default: cnt_q <= cnt_q;
        endcase
      end
      // overflow flag: hardware set beats vector clear and software
      if (run & (((mc_q == `CCOU_MC_UP) & (shadow_q != 16'h0000) &
                   (cnt_q >= shadow_q)) |
                 ((mc_q == `CCOU_MC_CONT) & (cnt_q == 16'hFFFF)) |
                 ((mc_q == `CCOU_MC_UPDN) & dn_q & (cnt_q == 16'h0001))))
        ovf_q <= 1'b1;
      else if (vacc & (vc == `CCOU_V_OVF))
        ovf_q <= 1'b0; // see RULE24
      else if (wr_go & wr_ok & (widx == `CCOU_I_CTRL))
        ovf_q <= wd_q[`CCOU_C_OVF];
    end
  end

  // period equal: channel 0 match, in either direction
  assign peq = arr_q & (cnt_q == ccr_v[15:0]); // see RULE18

  // ==========
  // channels
  // ==========
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch // see RULE5
      assign ctl_we[i] = wr_go & wr_ok &
                         (widx == `CCOU_I_CH0 + 2 * i);
      assign ccr_we[i] = wr_go & wr_ok &
                         (widx == `CCOU_I_CH0 + 2 * i + 1);
      assign ccr_rd[i] = rd_go & (ridx == `CCOU_I_CH0 + 2 * i + 1);
      if (i == 0) begin : g_c0
        assign flag_clr[i] = period_irq_ack; // see RULE22
      end else begin : g_cn
        assign flag_clr[i] = vacc & (vc == 2 * i); // see RULE24
      end
      ccou_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_q),
        .arrive(arr_q),
        .tclr(tclr_q),
        .count(cnt_q),
        .peq(peq),
        .in_a(cap_in_a[i]),
        .in_b(cap_in_b[i]),
        .ctl_we(ctl_we[i]),
        .ccr_we(ccr_we[i]),
        .ccr_rd(ccr_rd[i]),
        .flag_clr(flag_clr[i]),
        .wdata(wd_q[15:0]),
        .ctl_rv(ctl_rv[16 * i +: 16]),
        .ccr_v(ccr_v[16 * i +: 16]),
        .req(req[i]),
        .eq(ceq[i]),
        .out_q(chan_out[i])
      );
    end
  endgenerate

  // ==========
  // interrupt vectors
  // ==========
  // disabled sources do not show in the shared vector
  assign vpend = {ovf_q & ovie_q, (NCH > 2) ? req[NCH-1] : 1'b0, req[1]};
  assign vc = vcode(vpend);
  // any read or write of the vector register counts as access
  assign vacc = (wr_go & (widx == `CCOU_I_VECT)) |
                (rd_go & (ridx == `CCOU_I_VECT)); // see RULE24

  // requests gated by the global enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_period_q <= 1'b0;
      irq_shared_q <= 1'b0;
    end else begin
      irq_period_q <= gie_q & req[0]; // see RULE20 RULE21 RULE22
      irq_shared_q <= gie_q & (vpend != 3'h0); // see RULE20 RULE21
    end
  end
endmodule // ccou_top
`default_nettype wire

// *** logic/ccou_unused_placeholder_removed.v ***
`default_nettype none
`default_nettype wire

// *** pkg/ccou_defines.vh ***
// constants for the capture/compare output unit: register offsets,
// field positions, mode and vector codes
// assumes byte addresses on a 32-bit register bus, one word per register
`ifndef CCOU_DEFINES_VH
`define CCOU_DEFINES_VH
// register byte offsets
`define CCOU_A_CTRL 8'h00
`define CCOU_A_COUNT 8'h04
`define CCOU_A_VECT 8'h08
`define CCOU_A_CH0 8'h10
// register word indices
`define CCOU_I_CTRL 6'h00
`define CCOU_I_COUNT 6'h01
`define CCOU_I_VECT 6'h02
`define CCOU_I_CH0 6'h04
// global control fields
`define CCOU_C_MC 1:0
`define CCOU_C_CLR 2
`define CCOU_C_OVIE 3
`define CCOU_C_OVF 4
`define CCOU_C_GIE 5
// channel control fields
`define CCOU_K_EM 15:14
`define CCOU_K_IS 13:12
`define CCOU_K_SCS 11
`define CCOU_K_CAP 8
`define CCOU_K_OM 7:5
`define CCOU_K_IE 4
`define CCOU_K_OBIT 2
`define CCOU_K_COV 1
`define CCOU_K_FLG 0
// count modes
`define CCOU_MC_STOP 2'h0
`define CCOU_MC_UP 2'h1
`define CCOU_MC_CONT 2'h2
`define CCOU_MC_UPDN 2'h3
// shared vector codes
`define CCOU_V_NONE 4'h0
`define CCOU_V_CH1 4'h2
`define CCOU_V_CH2 4'h4
`define CCOU_V_OVF 4'hA
// bus responses
`define CCOU_R_OKAY 2'h0
`define CCOU_R_SLVERR 2'h2
`endif

// *** test/ccou_pins.sv ***
// pins model for the timer: drives the capture inputs
// assumes the bench asks for each level change through drive()
`default_nettype none
module ccou_pins (
  // clock
  input wire logic aclk,
  // capture pins toward the timer
  output var logic [2:0] cap_a,
  output var logic [2:0] cap_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // levels start low
  initial {cap_a, cap_b} = 6'h00;
  // changes land just after an edge, like a synchronous source
  task automatic drive(input logic sel_b, input int ch, input logic v);
    @(posedge aclk);
    if (sel_b) cap_b[ch] <= v;
    else cap_a[ch] <= v;
  endtask
endmodule // ccou_pins
`default_nettype wire

// *** test/ccou_top_sva.sv ***
// concurrent checks on the timer's bus and interrupt ports
// assumes it is bound into ccou_top and sees only that module's ports
`default_nettype none
module ccou_top_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  input wire logic awready_q,
  input wire logic wvalid,
  input wire logic wready_q,
  input wire logic bvalid_q,
  input wire logic bready,
  input wire logic [1:0] bresp_q,
  // read channels
  input wire logic arvalid,
  input wire logic arready_q,
  input wire logic rvalid_q,
  input wire logic rready,
  input wire logic [31:0] rdata_q,
  // dedicated interrupt
  input wire logic period_irq_ack,
  input wire logic irq_period_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // bus handshakes, all on aclk
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a response must not vanish before the master has taken it
  chk_b_stands:
    assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before handshake");
  chk_r_stands:
    assert property (rvalid_q && !rready |=> rvalid_q && $stable(rdata_q))
    else $error("read data dropped before handshake");
  // registers are 16 bits, so the upper half reads as zero
  chk_r_upper_zero:
    assert property (rvalid_q |-> rdata_q[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_read_answer:
    assert property (arvalid && arready_q |=> rvalid_q)
    else $error("read answer late");
  chk_write_answer:
    assert property (awvalid && awready_q && wvalid && wready_q
      |-> ##2 bvalid_q)
    else $error("write answer not on time");
  // one write and one read at a time
  chk_aw_refused:
    assert property (awvalid && awready_q |=> !awready_q && !wready_q)
    else $error("write readies stayed open after take");
  chk_ar_busy:
    assert property (rvalid_q |-> !arready_q)
    else $error("read ready open while answer pending");
  chk_ready_return:
    assert property (bvalid_q && bready |-> ##2 (awready_q && wready_q))
    else $error("readies not back");
  // ==========
  // dedicated interrupt
  // servicing drops the request, allowing for the one cycle lag
  chk_ack_clears:
    assert property (period_irq_ack |-> ##2 !irq_period_q)
    else $error("request not cleared by service");
endmodule // ccou_top_sva
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the capture/compare timer top
// assumes the pins model and the bound checker
`default_nettype none
`include "ccou_defines.vh"
bind ccou_top ccou_top_sva chk (.aclk, .aresetn, .awvalid, .awready_q,
  .wvalid, .wready_q, .bvalid_q, .bready, .bresp_q, .arvalid, .arready_q,
  .rvalid_q, .rready, .rdata_q, .period_irq_ack, .irq_period_q);
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // register offsets and design pins
  localparam logic [7:0] C0 = 8'h10, C1 = 8'h18, V1 = 8'h1C;
  localparam logic [7:0] V0 = 8'h14, C2 = 8'h20, V2 = 8'h24;
  localparam logic [7:0] CT = `CCOU_A_CTRL, CN = `CCOU_A_COUNT;
  localparam logic [7:0] VE = `CCOU_A_VECT;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic period_irq_ack, irq_period_q, irq_shared_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata_q;
  logic [3:0] wstrb;
  logic [1:0] bresp_q, rresp_q;
  logic [2:0] cap_in_a, cap_in_b, chan_out;
  int bad_count, n_checks;
  // one tick per clock, so each count lasts one cycle
  ccou_top #(.NCH(3), .TICK_DIV(1)) dut (.aclk, .aresetn, .awvalid,
    .awready_q, .awaddr, .wvalid, .wready_q, .wdata, .wstrb, .bvalid_q,
    .bready, .bresp_q, .arvalid, .arready_q, .araddr, .rvalid_q, .rready,
    .rdata_q, .rresp_q, .cap_in_a, .cap_in_b, .chan_out, .period_irq_ack,
    .irq_period_q, .irq_shared_q);
  ccou_pins pins (.aclk(aclk), .cap_a(cap_in_a), .cap_b(cap_in_b));
  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ==========
  // reporting
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hung();
    bad_count++;
    $display("[FAIL] wait expected done seen timeout");
    results();
  endtask
  task automatic cmp(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // ==========
  // bus and timing helpers
  task automatic tk(input int c);
    repeat (c) @(posedge aclk);
  endtask
  // bready waits for bvalid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (++n > 40) hung();
      if (awready_q) awvalid <= 1'b0;
      if (wready_q) wvalid <= 1'b0;
    end while (!bvalid_q);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    cmp("bresp", {30'h0, `CCOU_R_OKAY}, {30'h0, bresp_q});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (++n > 40) hung();
      if (arready_q) arvalid <= 1'b0;
    end while (!rvalid_q);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    v = rdata_q;
    r = rresp_q;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string s);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    cmp(s, e, v & m);
  endtask
  // one whole phase of an output; skip waits out a partial one first
  task automatic span(input int ch, input bit skip, output logic lv,
                      output int c);
    int n = 0;
    c = 0;
    lv = chan_out[ch];
    while (skip && chan_out[ch] === lv && n++ < 200) @(posedge aclk);
    lv = chan_out[ch];
    while (chan_out[ch] === lv && n++ < 200) begin
      @(posedge aclk);
      c++;
    end
    if (n >= 200) hung();
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0] r;
    rchk(CT, 32'hFFFFFFFF, 32'h0, "ctrl reset");
    rchk(VE, 32'hFFFFFFFF, 32'h0, "vector reset");
    rd(8'h0C, v, r);
    cmp("unmapped resp", {30'h0, `CCOU_R_SLVERR}, {30'h0, r});
    wr(C1, 16'h0004);
    tk(2);
    cmp("mode 0 high", 32'h1, {31'h0, chan_out[1]});
    wr(C1, 16'h0000);
    tk(2);
    cmp("mode 0 low", 32'h0, {31'h0, chan_out[1]});
    $display("test regs done");
  endtask
  // period 15, channel 1 at 5: count writes never match
  task automatic t_match();
    wr(CT, 16'h0004);
    wr(V0, 16'h000F);
    wr(V1, 16'h0005);
    wr(C1, 16'h0020);
    wr(CN, 16'h0005);
    tk(4);
    cmp("count write", 32'h0, {31'h0, chan_out[1]});
    wr(CT, {14'h0, `CCOU_MC_UP});
    tk(20);
    cmp("mode 1 set", 32'h1, {31'h0, chan_out[1]});
    rchk(C1, 32'h1, 32'h1, "match flag");
    wr(C1, 16'h00A0);
    tk(20);
    cmp("mode 5 clear", 32'h0, {31'h0, chan_out[1]});
    $display("test match done");
  endtask
  // every mode change keeps one mode bit set
  task automatic t_wave();
    logic [2:0] md [4] = '{3'h6, 3'h2, 3'h3, 3'h7};
    logic lv;
    int c;
    wr(C1, 16'h0080);
    span(1, 1'b1, lv, c);
    cmp("toggle phase", 32'h10, c);
    foreach (md[i]) begin
      wr(C1, {8'h00, md[i], 5'h00});
      span(1, 1'b1, lv, c);
      if (lv !== ~md[i][2]) span(1, 1'b0, lv, c);
      cmp("mode phase", 32'h0A, c);
    end
    $display("test wave done");
  endtask
  // period raised from 8 to 14 while rising; channel 1 toggles at 12
  task automatic t_updown();
    logic lv;
    int c;
    wr(C1, 16'h0080);
    wr(V1, 16'h000C);
    wr(V0, 16'h0008);
    wr(CT, 16'h0007);
    wr(V0, 16'h000E);
    span(1, 1'b1, lv, c);
    cmp("over the top", 32'h4, c);
    span(1, 1'b0, lv, c);
    cmp("through zero", 32'h18, c);
    $display("test updown done");
  endtask
  task automatic t_capture();
    wr(CT, 16'h0004);
    wr(CN, 16'h0007);
    wr(C2, 16'h4100);
    pins.drive(1'b0, 2, 1'b1);
    tk(3);
    rchk(C2, 32'h0B, 32'h09, "rise captured");
    rchk(V2, 32'hFFFF, 32'h7, "captured count");
    wr(CN, 16'h0009);
    pins.drive(1'b0, 2, 1'b0);
    tk(3);
    rchk(V2, 32'hFFFF, 32'h7, "fall ignored");
    pins.drive(1'b0, 2, 1'b1);
    wr(CN, 16'h000B);
    pins.drive(1'b0, 2, 1'b0);
    pins.drive(1'b0, 2, 1'b1);
    tk(3);
    rchk(C2, 32'h2, 32'h2, "overflow");
    rchk(V2, 32'hFFFF, 32'hB, "second count");
    wr(C2, 16'h5100);
    rchk(C2, 32'h3, 32'h0, "overflow cleared");
    pins.drive(1'b1, 2, 1'b1);
    tk(3);
    rchk(C2, 32'h9, 32'h9, "input b");
    wr(CN, 16'h0003);
    wr(C1, 16'hE100);
    wr(C1, 16'hF100);
    tk(3);
    rchk(V1, 32'hFFFF, 32'h3, "soft capture");
    rchk(C1, 32'h1, 32'h1, "soft flag");
    $display("test capture done");
  endtask
  // shared vector order: channel 1, channel 2, overflow
  task automatic t_irq();
    wr(C1, 16'h0011);
    wr(C2, 16'h0011);
    tk(3);
    cmp("no gie", 32'h0, {31'h0, irq_shared_q});
    wr(CT, 16'h0038);
    tk(3);
    cmp("shared", 32'h1, {31'h0, irq_shared_q});
    rchk(VE, 32'hFFFF, {28'h0, `CCOU_V_CH1}, "vec 1");
    rchk(VE, 32'hFFFF, {28'h0, `CCOU_V_CH2}, "vec 2");
    rchk(VE, 32'hFFFF, {28'h0, `CCOU_V_OVF}, "vec ovf");
    rchk(VE, 32'hFFFF, {28'h0, `CCOU_V_NONE}, "vec none");
    tk(3);
    cmp("shared done", 32'h0, {31'h0, irq_shared_q});
    wr(C0, 16'h0011);
    tk(3);
    cmp("dedicated", 32'h1, {31'h0, irq_period_q});
    @(posedge aclk);
    period_irq_ack <= 1'b1;
    @(posedge aclk);
    period_irq_ack <= 1'b0;
    tk(3);
    cmp("serviced", 32'h0, {31'h0, irq_period_q});
    rchk(C0, 32'h1, 32'h0, "ch0 flag");
    $display("test irq done");
  endtask
  // ==========
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    period_irq_ack = 1'b0;
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'hF;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_match();
    t_wave();
    t_updown();
    t_capture();
    t_irq();
    results();
  end
endmodule // testbench
`default_nettype wire
